// ---- rtl/cwu_top.v ----
// Complementary wave unit: half/full-bridge, push-pull, steering outputs.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "cwu_consts.vh"
module cwu_top (
	input  wire        clk_sys_i,
	input  wire        rst_i,
	input  wire [3:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	input  wire        data_in_i,
	input  wire [3:0]  shutdown_src_i,
	output reg         bridge_output_a_o,
	output reg         bridge_output_b_o,
	output reg         bridge_output_c_o,
	output reg         bridge_output_d_o
);
	// Control zero: enable, load request, mode.
	reg [7:0] wave_control_zero;
	// Control one: per_output_polarity in bits 3..0 (d c b a).
	reg [7:0] wave_control_one;
	// Rising and falling dead-band values as written by software.
	reg [5:0] db_rise_wr;
	reg [5:0] db_fall_wr;
	// Active dead-band values used by the timers (double buffered).
	reg [5:0] db_rise;
	reg [5:0] db_fall;
	// Shutdown: state, auto-restart, override pairs, source enables.
	reg [7:0] shut_ctrl;
	reg [3:0] shut_src_en;
	// Steering: enables in 3..0, override levels in 7..4.
	reg [7:0] steer_ctrl;
	// Steering enables in use (synchronised copy in mode 001).
	reg [3:0] steer_act;
	// Bus handshake: set in the cycle the answer is given.
	reg       bus_ack;
	// Data input after the synchroniser and its previous value.
	wire      data_s;
	reg       data_d;
	// Synchronised shutdown sources.
	wire [3:0] src_s;
	// Push-pull sequencer state: high means next pulse goes to b.
	reg       pp_to_b;
	// Latched push-pull steering for the current pulse.
	reg       pp_cur_b;
	// Full-bridge direction in use (high means reverse) and run flag.
	reg       fb_rev;
	reg       fb_run;
	// Gate of the modulated output during direction-switch dead band.
	reg       fb_hold;
	reg [5:0] fb_cnt;
	// Dead-band buffer load pending and falling-edge seen.
	reg       ld_pend;
	reg       ld_fell;

	wire       en       = wave_control_zero[`CWU_F_EN];
	wire [2:0] mode     = wave_control_zero[2:0];
	wire       rise_e   = data_s & ~data_d;
	wire       fall_e   = ~data_s & data_d;
	wire       shut_now = |(src_s & shut_src_en);
	wire       shut     = shut_ctrl[`CWU_F_SHUT];
	wire       full_br  = (mode[2:1] == 2'b01);

	// Returns the pin level for a logical level and polarity bit.
	function pol_apply;
		input lvl;
		input pol;
		pol_apply = pol ? lvl : ~lvl;
	endfunction

	cwu_sync u_sync_data (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.async_i   (data_in_i),
		.sync_o    (data_s)
	);

	// Shutdown sources come from pins too, so each is synchronised.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
			cwu_sync u_sync_src (
				.clk_sys_i (clk_sys_i),
				.rst_i     (rst_i),
				.async_i   (shutdown_src_i[gi]),
				.sync_o    (src_s[gi])
			);
		end
	endgenerate

	// Bus answers one cycle after the request is first seen.
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack;

	// Register writes, shutdown state and dead-band buffer loading.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			bus_ack           <= 1'b0;
			wave_control_zero <= `CWU_RST_CTRL0;
			wave_control_one  <= `CWU_RST_CTRL1;
			db_rise_wr        <= `CWU_RST_DB;
			db_fall_wr        <= `CWU_RST_DB;
			db_rise           <= `CWU_RST_DB;
			db_fall           <= `CWU_RST_DB;
			shut_ctrl         <= `CWU_RST_SHUT;
			shut_src_en       <= 4'h0;
			steer_ctrl        <= `CWU_RST_STEER;
			ld_pend           <= 1'b0;
			ld_fell           <= 1'b0;
			avs_readdata_o    <= 32'h0;
		end else begin
			bus_ack <= (avs_read_i | avs_write_i) & ~bus_ack;
			if (shut_now)
				shut_ctrl[`CWU_F_SHUT] <= 1'b1;
			else if (shut_ctrl[`CWU_F_REN] && rise_e)
				shut_ctrl[`CWU_F_SHUT] <= 1'b0;
			if (avs_write_i && !bus_ack) begin
				case (avs_address_i)
				`CWU_IDX_CTRL0: begin
					wave_control_zero <= avs_writedata_i[7:0];
				end
				`CWU_IDX_CTRL1: begin
					wave_control_one <= avs_writedata_i[7:0];
				end
				`CWU_IDX_DBR: begin
					db_rise_wr <= avs_writedata_i[5:0];
					if (!en)
						db_rise <= avs_writedata_i[5:0];
				end
				`CWU_IDX_DBF: begin
					db_fall_wr <= avs_writedata_i[5:0];
					if (!en)
						db_fall <= avs_writedata_i[5:0];
				end
				`CWU_IDX_SHUT: begin
					// Set by a source wins over a software clear.
					shut_ctrl <= {avs_writedata_i[7] | shut_now,
						avs_writedata_i[6:0]};
					shut_src_en <= avs_writedata_i[11:8];
				end
				`CWU_IDX_STEER: begin
					steer_ctrl <= avs_writedata_i[7:0];
				end
				default: ;
				endcase
			end
			// Load request: rise after the first fall applies values.
			if (wave_control_zero[`CWU_F_LD] && en && !ld_pend) begin
				ld_pend <= 1'b1;
				ld_fell <= 1'b0;
				wave_control_zero[`CWU_F_LD] <= 1'b0;
			end
			if (ld_pend && fall_e)
				ld_fell <= 1'b1;
			if (ld_pend && ld_fell && rise_e) begin
				db_rise <= db_rise_wr;
				db_fall <= db_fall_wr;
				ld_pend <= 1'b0;
			end
			if (avs_read_i && !bus_ack) begin
				case (avs_address_i)
				`CWU_IDX_CTRL0:  avs_readdata_o <= {24'h0,
					wave_control_zero};
				`CWU_IDX_CTRL1:  avs_readdata_o <= {24'h0,
					wave_control_one};
				`CWU_IDX_DBR:    avs_readdata_o <= {26'h0, db_rise_wr};
				`CWU_IDX_DBF:    avs_readdata_o <= {26'h0, db_fall_wr};
				`CWU_IDX_SHUT:   avs_readdata_o <= {20'h0, shut_src_en,
					shut_ctrl};
				`CWU_IDX_STEER:  avs_readdata_o <= {24'h0, steer_ctrl};
				`CWU_IDX_STATUS: avs_readdata_o <= {25'h0, ld_pend,
					fb_hold, fb_rev, pp_to_b, data_s, shut, en};
				default:         avs_readdata_o <= 32'h0;
				endcase
			end
		end
	end

	// Synchronous steering picks up new enables on a rising data edge.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			data_d    <= 1'b0;
			steer_act <= 4'h0;
		end else begin
			data_d <= data_s;
			if (mode != `CWU_MODE_SSTEER || rise_e)
				steer_act <= steer_ctrl[3:0];
		end
	end

	// Push-pull sequencer alternates pulses between a and b.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			pp_to_b  <= 1'b0;
			pp_cur_b <= 1'b0;
		end else if (!en || shut) begin
			pp_to_b  <= 1'b0;
			pp_cur_b <= 1'b0;
		end else if (rise_e) begin
			pp_cur_b <= pp_to_b;
			pp_to_b  <= ~pp_to_b;
		end
	end

	// Direction follows mode bit zero on a rising edge; entry takes it as set.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			fb_run  <= 1'b0;
			fb_rev  <= 1'b0;
			fb_hold <= 1'b0;
			fb_cnt  <= `CWU_RST_DB;
		end else if (!en || !full_br || !fb_run) begin
			fb_run  <= en & full_br;
			fb_rev  <= mode[0];
			fb_hold <= 1'b0;
			fb_cnt  <= `CWU_RST_DB;
		end else if (rise_e && fb_rev != mode[0]) begin
			fb_rev <= mode[0];
			fb_cnt  <= `CWU_RST_DB;
			fb_hold <= mode[0] ? (db_rise != `CWU_RST_DB)
				: (db_fall != `CWU_RST_DB);
		end else if (fb_hold) begin
			if (fb_cnt + 6'h01 >= (fb_rev ? db_rise : db_fall))
				fb_hold <= 1'b0;
			else
				fb_cnt <= fb_cnt + 6'h01;
		end
	end

	// Half-bridge delayed turn-on for each complementary output.
	wire hb_a;
	wire hb_b;

	cwu_deadband u_db_rise (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.level_i   (data_s),
		.count_i   (db_rise),
		.level_o   (hb_a)
	);

	cwu_deadband u_db_fall (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.level_i   (~data_s),
		.count_i   (db_fall),
		.level_o   (hb_b)
	);

	// Logical levels of outputs a to d before polarity and shutdown.
	reg [3:0] lvl;
	// Outputs that use their polarity bit (all, or only the steered ones in steering modes).
	reg [3:0] use_pol;
	// Pin levels after polarity, override and shutdown.
	reg [3:0] next_pin;
	integer   k;

	// Mode decode of the logical output levels.
	always @* begin
		lvl     = 4'h0;
		use_pol = 4'hf;
		case (mode)
		`CWU_MODE_HALF: begin
			lvl = {hb_b, hb_a, hb_b, hb_a};
		end
		`CWU_MODE_PUSH: begin
			// c copies a, d copies b
			lvl[0] = data_s & ~(rise_e ? pp_to_b : pp_cur_b);
			lvl[1] = data_s & (rise_e ? pp_to_b : pp_cur_b);
			lvl[2] = lvl[0];
			lvl[3] = lvl[1];
		end
		`CWU_MODE_FWD, `CWU_MODE_REV: begin
			// dead band only on modulated output
			if (!(fb_run ? fb_rev : mode[0])) begin
				lvl = {data_s & ~fb_hold, 1'b0, 1'b0, 1'b1};
			end else begin
				lvl = {1'b0, 1'b1, data_s & ~fb_hold, 1'b0};
			end
		end
		default: begin
			// Steering: data on steered pins, override elsewhere.
			lvl     = {4{data_s}};
			use_pol = steer_act;
		end
		endcase
	end

	always @* begin
		for (k = 0; k < 4; k = k + 1) begin
			if (!use_pol[k])
				next_pin[k] = steer_ctrl[4+k];
			else if (shut)
				next_pin[k] = k[0] ? shut_ctrl[3] : shut_ctrl[2];
			else
				next_pin[k] = pol_apply(lvl[k], wave_control_one[k]);
		end
	end

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			bridge_output_a_o <= 1'b0;
			bridge_output_b_o <= 1'b0;
			bridge_output_c_o <= 1'b0;
			bridge_output_d_o <= 1'b0;
		end else if (!en) begin
			bridge_output_a_o <= 1'b0;
			bridge_output_b_o <= 1'b0;
			bridge_output_c_o <= 1'b0;
			bridge_output_d_o <= 1'b0;
		end else begin
			bridge_output_a_o <= next_pin[0];
			bridge_output_b_o <= next_pin[1];
			bridge_output_c_o <= next_pin[2];
			bridge_output_d_o <= next_pin[3];
		end
	end
endmodule

// ---- rtl/cwu_consts.vh ----
// Constants of the complementary wave unit: offsets, fields, resets, timing.
`ifndef CWU_CONSTS_VH
`define CWU_CONSTS_VH
// Register word offsets (byte address = 4 * index).
`define CWU_IDX_CTRL0    4'h0
`define CWU_IDX_CTRL1    4'h1
`define CWU_IDX_DBR      4'h2
`define CWU_IDX_DBF      4'h3
`define CWU_IDX_SHUT     4'h4
`define CWU_IDX_STEER    4'h5
`define CWU_IDX_STATUS   4'h6
// Control zero fields.
`define CWU_F_EN         7
`define CWU_F_LD         6
// Mode encodings.
`define CWU_MODE_ASTEER  3'h0
`define CWU_MODE_SSTEER  3'h1
`define CWU_MODE_FWD     3'h2
`define CWU_MODE_REV     3'h3
`define CWU_MODE_HALF    3'h4
`define CWU_MODE_PUSH    3'h5
// Shutdown register fields.
`define CWU_F_SHUT       7
`define CWU_F_REN        6
`define CWU_F_SRC_LO     0
// Reset values.
`define CWU_RST_CTRL0    8'h00
`define CWU_RST_CTRL1    8'h00
`define CWU_RST_DB       6'h00
`define CWU_RST_SHUT     8'h14
`define CWU_RST_STEER    8'h00
// Dead-band counter width.
`define CWU_DB_W         6
// Bus answers a request in this many cycles after it is first seen.
`define CWU_BUS_WAIT     1
`endif

// ---- rtl/cwu_sync.v ----
// Two-flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/10ps
module cwu_sync (
	input  wire clk_sys_i,
	input  wire rst_i,
	input  wire async_i,
	output reg  sync_o
);
	// First stage, read only by the second stage.
	reg meta;

	// Two flops in series give the level time to settle.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			meta   <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule

// ---- rtl/cwu_deadband.v ----
// Dead-band timer that delays the turn-on of one output after its cause.
`timescale 1ns/10ps
`include "cwu_consts.vh"
module cwu_deadband (
	input  wire                 clk_sys_i,
	input  wire                 rst_i,
	input  wire                 level_i,
	input  wire [`CWU_DB_W-1:0] count_i,
	output reg                  level_o
);
	// Counts elapsed clock periods since the last rise of the level.
	reg [`CWU_DB_W-1:0] elapsed;
	// Previous input level for edge detection.
	reg                 prev;

	// A rise starts the count; output rises once the count is reached.
	// A fall ends the pulse at once, so a short pulse never appears.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			elapsed <= `CWU_RST_DB;
			prev    <= 1'b0;
			level_o <= 1'b0;
		end else begin
			prev <= level_i;
			if (!level_i) begin
				elapsed <= `CWU_RST_DB;
				level_o <= 1'b0;
			end else if (!prev) begin
				// Zero count means no dead band.
				elapsed <= `CWU_RST_DB;
				level_o <= (count_i == `CWU_RST_DB);
			end else if (!level_o) begin
				if (elapsed + 6'h01 >= count_i)
					level_o <= 1'b1;
				else
					elapsed <= elapsed + 6'h01;
			end
		end
	end
endmodule

// ---- tb/cwu_gate_model.sv ----
// Gate drivers of the two bridge legs; counts shoot-through cycles.
`timescale 1ns/10ps
module cwu_gate_model (
	input  wire        clk_sys_i,
	input  wire        arm_i,
	input  wire [3:0]  gate_i,
	output reg  [31:0] n_shoot_o = 32'h0
);
	// Gates are active high while armed; legs are a/b and c/d.
	// leg overlap count
	always @(posedge clk_sys_i) begin
		if (arm_i && ((gate_i[3] && gate_i[2]) || (gate_i[1] && gate_i[0])))
			n_shoot_o <= n_shoot_o + 32'h1;
	end
endmodule

// ---- tb/cwu_top_monitor.sv ----
// Concurrent checks on the wave unit pins, tracking control writes.
`timescale 1ns/10ps
module cwu_monitor (
	input wire        clk_sys_i,
	input wire        rst_i,
	input wire [3:0]  avs_address_i,
	input wire        avs_read_i,
	input wire        avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [31:0] avs_readdata_o,
	input wire        avs_waitrequest_o,
	input wire        data_in_i,
	input wire [3:0]  shutdown_src_i,
	input wire        bridge_output_a_o,
	input wire        bridge_output_b_o,
	input wire        bridge_output_c_o,
	input wire        bridge_output_d_o
);
	reg        en;
	reg  [2:0] md;
	reg  [3:0] pl;
	reg  [3:0] age;
	wire       wok = avs_write_i && !avs_waitrequest_o;
	wire       ok = en && age > 4'h4;
	wire       xa = bridge_output_a_o ~^ pl[0];
	wire       xb = bridge_output_b_o ~^ pl[1];
	wire       xc = bridge_output_c_o ~^ pl[2];
	wire       xd = bridge_output_d_o ~^ pl[3];
	// Shadow of enable, mode and polarity; age counts settle time.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			en <= 1'h0;
			md <= 3'h0;
			pl <= 4'h0;
			age <= 4'h0;
		end else if (wok && avs_address_i == 4'h0) begin
			en <= avs_writedata_i[7];
			md <= avs_writedata_i[2:0];
			age <= 4'h0;
		end else if (wok && avs_address_i == 4'h1) begin
			pl <= avs_writedata_i[3:0];
			age <= 4'h0;
		end else if (age != 4'hf) begin
			age <= age + 4'h1;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_off;
		(!en && age > 4'h4) |-> !(bridge_output_a_o || bridge_output_b_o
			|| bridge_output_c_o || bridge_output_d_o);
	endproperty
	a_off: assert property (p_off)
		else $error("outputs not idle while disabled");
	property p_nover;
		(ok && md == 3'h4) |-> !(xa && xb);
	endproperty
	a_nover: assert property (p_nover)
		else $error("half bridge outputs overlap");
	property p_half_cd;
		(ok && md == 3'h4) |-> ((xa == xc) && (xb == xd));
	endproperty
	a_half_cd: assert property (p_half_cd)
		else $error("half bridge c or d not following");
	property p_push_cd;
		(ok && md == 3'h5) |-> ((xa == xc) && (xb == xd));
	endproperty
	a_push_cd: assert property (p_push_cd)
		else $error("push pull c or d not copying");
	property p_push_alt;
		(ok && md == 3'h5) |-> !(xa && xb);
	endproperty
	a_push_alt: assert property (p_push_alt)
		else $error("push pull a and b both active");
	property p_fb_ac;
		(ok && md[2:1] == 2'h1) |-> (xa != xc);
	endproperty
	a_fb_ac: assert property (p_fb_ac)
		else $error("full bridge a and c not opposite");
	property p_fb_bd;
		(ok && md[2:1] == 2'h1) |-> !(xb && xd);
	endproperty
	a_fb_bd: assert property (p_fb_bd)
		else $error("full bridge b and d both active");
	property p_sync;
		(ok && md == 3'h4 && $rose(xa)) |-> $past(data_in_i, 3);
	endproperty
	a_sync: assert property (p_sync)
		else $error("output a rose too soon after data");
endmodule
bind cwu_top cwu_monitor mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.data_in_i(data_in_i), .shutdown_src_i(shutdown_src_i),
	.bridge_output_a_o(bridge_output_a_o),
	.bridge_output_b_o(bridge_output_b_o),
	.bridge_output_c_o(bridge_output_c_o),
	.bridge_output_d_o(bridge_output_d_o));

// ---- tb/tb_complementary_waveform_modes.sv ----
// Bench for the complementary wave unit output modes.
`timescale 1ns/10ps
module tb_complementary_waveform_modes;
	reg         clk_sys_i = 1'h0;
	reg         rst_i = 1'h1;
	reg         rd = 1'h0;
	reg         wr = 1'h0;
	reg         din = 1'h0;
	reg         arm = 1'h0;
	reg  [3:0]  shut = 4'h0;
	reg  [3:0]  adr = 4'h0;
	reg  [31:0] wd = 32'h0;
	reg  [31:0] got;
	reg  [11:0] tbl [0:9];
	wire [31:0] rdat;
	wire [31:0] nsh;
	wire        wt, a, b, c, d;
	wire [3:0]  o = {a, b, c, d};
	integer     n_mismatch = 0, n_compared = 0, cyc = 0, i, t0, t1;
	cwu_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt), .data_in_i(din),
		.shutdown_src_i(shut), .bridge_output_a_o(a),
		.bridge_output_b_o(b), .bridge_output_c_o(c), .bridge_output_d_o(d));
	cwu_gate_model gm (.clk_sys_i(clk_sys_i), .arm_i(arm), .gate_i(o),
		.n_shoot_o(nsh));
	initial forever #10 clk_sys_i = ~clk_sys_i;
	// Cuts a hang short.
	always @(posedge clk_sys_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			give_verdict;
		end
	end
	task give_verdict;
		begin
			$display("compared %0d mismatched %0d", n_compared, n_mismatch);
			if (n_mismatch == 0 && n_compared > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task idle(input integer n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	// One bus cycle, held until waitrequest is sampled low.
	task bus(input w, input [3:0] ad, input [31:0] v);
		begin
			@(posedge clk_sys_i);
			rd <= ~w;
			wr <= w;
			adr <= ad;
			wd <= v;
			@(posedge clk_sys_i);
			while (wt !== 1'h0) @(posedge clk_sys_i);
			got = rdat;
			rd <= 1'h0;
			wr <= 1'h0;
		end
	endtask
	task cmp(input [31:0] g, input [31:0] e);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	// Disable, set polarity, enable in the given mode.
	task cfg(input [2:0] m, input [3:0] p);
		begin
			bus(1'h1, 4'h0, 32'h0);
			bus(1'h1, 4'h1, {28'h0, p});
			bus(1'h1, 4'h0, {24'h0, 5'h10, m});
		end
	endtask
	task pulse(input [3:0] e);
		begin
			din <= 1'h1;
			idle(8);
			cmp(o, e);
			din <= 1'h0;
			idle(8);
		end
	endtask
	// Cycles from data rise to output a rise in half bridge.
	task meas(input [5:0] v, output integer n);
		begin
			bus(1'h1, 4'h0, 32'h0);
			bus(1'h1, 4'h2, {26'h0, v});
			cfg(3'h4, 4'hf);
			idle(12);
			din <= 1'h1;
			n = 0;
			while (a !== 1'h1 && n < 100) begin
				idle(1);
				n = n + 1;
			end
			din <= 1'h0;
			idle(12);
		end
	endtask
	initial begin
		tbl[0] = {3'h4, 4'hf, 1'h1, 4'ha};
		tbl[1] = {3'h4, 4'hf, 1'h0, 4'h5};
		tbl[2] = {3'h4, 4'h0, 1'h1, 4'h5};
		tbl[3] = {3'h4, 4'h0, 1'h0, 4'ha};
		tbl[4] = {3'h2, 4'hf, 1'h1, 4'h9};
		tbl[5] = {3'h2, 4'hf, 1'h0, 4'h8};
		tbl[6] = {3'h3, 4'hf, 1'h1, 4'h6};
		tbl[7] = {3'h3, 4'hf, 1'h0, 4'h2};
		tbl[8] = {3'h2, 4'h0, 1'h1, 4'h6};
		tbl[9] = {3'h5, 4'hf, 1'h0, 4'h0};
		idle(20);
		rst_i <= 1'h0;
		idle(1);
		cmp(o, 32'h0);
		bus(1'h0, 4'h0, 32'h0);
		cmp(got, 32'h0);
		bus(1'h0, 4'h4, 32'h0);
		cmp(got, 32'h14);
		bus(1'h1, 4'h9, 32'hff);
		bus(1'h0, 4'h9, 32'h0);
		cmp(got, 32'h0);
		$display("test reset done");
		for (i = 0; i < 10; i = i + 1) begin
			cfg(tbl[i][11:9], tbl[i][8:5]);
			din <= tbl[i][4];
			idle(12);
			cmp(o, tbl[i][3:0]);
		end
		$display("test table done");
		arm <= 1'h1;
		meas(6'h0, t0);
		meas(6'h5, t1);
		cmp(t1 - t0, 32'h5);
		$display("test dead band done");
		cfg(3'h5, 4'hf);
		pulse(4'ha);
		pulse(4'h5);
		pulse(4'ha);
		cfg(3'h5, 4'hf);
		pulse(4'ha);
		pulse(4'h5);
		$display("test push pull done");
		// Shutdown in push-pull: overrides, set wins, sequencer reset.
		bus(1'h1, 4'h4, 32'h114);
		pulse(4'ha);
		shut <= 4'h1;
		idle(12);
		cmp(o, 32'ha);
		bus(1'h1, 4'h4, 32'h114);
		bus(1'h0, 4'h6, 32'h0);
		cmp(got & 32'hf, 32'h3);
		shut <= 4'h0;
		idle(4);
		bus(1'h1, 4'h4, 32'h114);
		idle(4);
		pulse(4'ha);
		$display("test shutdown done");
		bus(1'h1, 4'h0, 32'h0);
		bus(1'h1, 4'h2, 32'h5);
		cfg(3'h2, 4'hf);
		idle(12);
		cmp(o, 32'h8);
		bus(1'h1, 4'h0, 32'h83);
		idle(10);
		cmp(o, 32'h8);
		din <= 1'h1;
		t0 = 0;
		while (c !== 1'h1 && t0 < 50) begin
			idle(1);
			t0 = t0 + 1;
		end
		cmp(o, 32'h2);
		idle(12);
		cmp(o, 32'h6);
		arm <= 1'h0;
		cmp(nsh, 32'h0);
		$display("test direction done");
		// Steering: asynchronous, then synchronous update on a rise.
		bus(1'h1, 4'h5, 32'h51);
		cfg(3'h0, 4'hf);
		din <= 1'h1;
		idle(12);
		cmp(o, 32'ha);
		cfg(3'h1, 4'hf);
		bus(1'h1, 4'h5, 32'h52);
		idle(12);
		cmp(o, 32'ha);
		din <= 1'h0;
		idle(12);
		din <= 1'h1;
		idle(12);
		cmp(o, 32'he);
		cfg(3'h0, 4'h0);
		idle(12);
		cmp(o, 32'ha);
		$display("test steering done");
		// Reset again in mid-run while the outputs are active.
		rst_i <= 1'h1;
		idle(2);
		rst_i <= 1'h0;
		idle(1);
		cmp(o, 32'h0);
		bus(1'h0, 4'h0, 32'h0);
		cmp(got, 32'h0);
		$display("test reset again done");
		give_verdict;
	end
endmodule
